// file: rtl/csd_pkg.sv
package csd_pkg;

  localparam int ADDR_W = 20;
  localparam int CTRL_W = 16;
  localparam int PERIPH_N = 7;
  localparam int MID_N = 4;

  // Bus cycle status codes
  typedef enum logic [2:0] {
    CSD_CYC_INT_ACK = 3'h0,
    CSD_CYC_IO_READ = 3'h1,
    CSD_CYC_IO_WRITE = 3'h2,
    CSD_CYC_HALT = 3'h3,
    CSD_CYC_FETCH = 3'h4,
    CSD_CYC_MEM_READ = 3'h5,
    CSD_CYC_MEM_WRITE = 3'h6,
    CSD_CYC_PASSIVE = 3'h7
  } csd_cycle_t;

  // Shared field layout of every control word
  localparam int F_WAIT_LO = 0;
  localparam int F_WAIT_HI = 1;
  localparam int F_RDY_DIS = 2;
  // Boot and low selects: address bits 17:10
  localparam int F_A17_LO = 6;
  localparam int F_A17_HI = 13;
  // Mid-range base: address bits 19:13
  localparam int F_MID_LO = 9;
  localparam int F_MID_HI = 15;
  // Peripheral base: address bits 19:10
  localparam int F_PER_LO = 6;
  localparam int F_PER_HI = 15;
  // Shared register fields
  localparam int F_SIZE_LO = 8;
  localparam int F_SIZE_HI = 14;
  localparam int F_SPACE = 6;

  localparam logic [CTRL_W-1:0] BOOT_CTRL_RESET = 16'h3fc3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [1:0] TOP_QUAD = 2'h3;
  localparam logic [1:0] LOW_QUAD = 2'h0;
  localparam logic [2:0] PERIPH_HOLE = 3'h7;

endpackage : csd_pkg

// file: rtl/csd_wait.sv
`timescale 1ns/10ps
// Wait-state engine: one wait state per clock, then optional bus ready
module csd_wait
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [1:0] wait_count_in,
  input wire logic ready_disable_in,
  input wire logic bus_ready_in,
  input wire logic clear_in,
  output logic done_out
);

  logic [1:0] count;
  logic ready_disable;
  logic busy;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count <= 2'h0;
      ready_disable <= 1'b0;
      busy <= 1'b0;
    end
    else if (load_in)
    begin
      count <= wait_count_in;
      ready_disable <= ready_disable_in;
      busy <= 1'b1;
    end
    else if (clear_in)
    begin
      busy <= 1'b0;
      count <= 2'h0;
    end
    else if (busy && count != 2'h0)
    begin
      count <= count - 2'h1;
    end
  end

  // Minimum count first; with ready enabled the pin must also agree
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_out <= 1'b0;
    end
    else if (load_in || clear_in)
    begin
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= busy && count == 2'h0 && (ready_disable || bus_ready_in);
    end
  end

endmodule : csd_wait

// file: rtl/csd_decoder.sv
`timescale 1ns/10ps
module csd_decoder
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cyc_start_in,
  input wire logic cyc_end_in,
  input wire logic [19:0] cyc_addr_in,
  input wire logic [2:0] cyc_status_in,
  input wire logic ctrl_block_hit_in,
  input wire logic bus_ready_in,
  input wire logic [15:0] cfg_data_in,
  input wire logic boot_select_ctrl_wr_in,
  input wire logic low_select_ctrl_wr_in,
  input wire logic mid_select_ctrl_wr_in,
  input wire logic shared_select_ctrl_wr_in,
  input wire logic periph_select_ctrl_wr_in,
  output logic boot_mem_select_n_out,
  output logic low_mem_select_n_out,
  output logic [3:0] mid_mem_select_n_out,
  output logic [6:0] periph_select_n_out,
  output logic cycle_ready_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration

  logic [15:0] boot_select_ctrl;
  logic [15:0] low_select_ctrl;
  logic [15:0] mid_select_ctrl;
  logic [15:0] shared_select_ctrl;
  logic [15:0] periph_select_ctrl;
  logic low_written;
  logic mid_written;
  logic shared_written;
  logic periph_written;
  logic ready_sync1;
  logic ready_sync2;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      boot_select_ctrl <= csd_pkg::BOOT_CTRL_RESET;
      low_select_ctrl <= csd_pkg::CTRL_RESET;
      mid_select_ctrl <= csd_pkg::CTRL_RESET;
      shared_select_ctrl <= csd_pkg::CTRL_RESET;
      periph_select_ctrl <= csd_pkg::CTRL_RESET;
    end
    else
    begin
      if (boot_select_ctrl_wr_in)
        boot_select_ctrl <= cfg_data_in;
      if (low_select_ctrl_wr_in)
        low_select_ctrl <= cfg_data_in;
      if (mid_select_ctrl_wr_in)
        mid_select_ctrl <= cfg_data_in;
      if (shared_select_ctrl_wr_in)
        shared_select_ctrl <= cfg_data_in;
      if (periph_select_ctrl_wr_in)
        periph_select_ctrl <= cfg_data_in;
    end
  end

  // Everything but the boot select stays dark until software programs it
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      low_written <= 1'b0;
      mid_written <= 1'b0;
      shared_written <= 1'b0;
      periph_written <= 1'b0;
    end
    else
    begin
      low_written <= low_written | low_select_ctrl_wr_in;
      mid_written <= mid_written | mid_select_ctrl_wr_in;
      shared_written <= shared_written | shared_select_ctrl_wr_in;
      periph_written <= periph_written | periph_select_ctrl_wr_in;
    end
  end

  // Bus ready is a pin: two flops before anything looks at it
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ready_sync1 <= 1'b0;
      ready_sync2 <= 1'b0;
    end
    else
    begin
      ready_sync1 <= bus_ready_in;
      ready_sync2 <= ready_sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  // Log2 of a one-hot-from-top block size; don't-care low bits are ignored
  function automatic logic [2:0] size_shift(input logic [6:0] size);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 0; i < 7; i++)
      if (size[i])
        s = 3'(i);
    return s;
  endfunction : size_shift

  function automatic logic [1:0] wait_field(input logic [15:0] ctrl);
    return ctrl[csd_pkg::F_WAIT_HI:csd_pkg::F_WAIT_LO];
  endfunction : wait_field

  logic mem_cycle;
  logic io_cycle;
  logic periph_space_sel;
  logic [7:0] a_mid8;
  logic [7:0] boot_base;
  logic [7:0] low_end;
  logic [6:0] mid_base;
  logic [9:0] per_base;
  logic [2:0] mid_shift;
  logic [8:0] mid_off;
  logic [8:0] mid_blocks;
  logic [8:0] mid_span;
  logic hit_boot;
  logic hit_low;
  logic hit_mid;
  logic hit_per;
  logic [1:0] mid_idx;
  logic [2:0] per_idx;
  logic [1:0] next_wait;
  logic next_rdis;

  always_comb
  begin
    // Cycle source plays no part here
    mem_cycle = cyc_status_in == csd_pkg::CSD_CYC_MEM_READ
      || cyc_status_in == csd_pkg::CSD_CYC_MEM_WRITE
      || cyc_status_in == csd_pkg::CSD_CYC_FETCH;
    io_cycle = cyc_status_in == csd_pkg::CSD_CYC_IO_READ
      || cyc_status_in == csd_pkg::CSD_CYC_IO_WRITE;
    periph_space_sel = shared_select_ctrl[csd_pkg::F_SPACE];
    a_mid8 = cyc_addr_in[17:10];
    boot_base = boot_select_ctrl[csd_pkg::F_A17_HI:csd_pkg::F_A17_LO];
    low_end = low_select_ctrl[csd_pkg::F_A17_HI:csd_pkg::F_A17_LO];
    mid_base = mid_select_ctrl[csd_pkg::F_MID_HI:csd_pkg::F_MID_LO];
    per_base = periph_select_ctrl[csd_pkg::F_PER_HI:csd_pkg::F_PER_LO];
    mid_shift = size_shift(shared_select_ctrl[csd_pkg::F_SIZE_HI:csd_pkg::F_SIZE_LO]);
    // Offsets in 2 Kbyte units, so a block of the smallest size is one unit
    mid_off = cyc_addr_in[19:11] - {mid_base, 2'h0};
    mid_blocks = 9'h001 << mid_shift;
    mid_span = 9'(mid_blocks << 2);
    hit_boot = mem_cycle && !ctrl_block_hit_in
      && cyc_addr_in[19:18] == csd_pkg::TOP_QUAD && a_mid8 >= boot_base;
    hit_low = low_written && mem_cycle && !ctrl_block_hit_in
      && cyc_addr_in[19:18] == csd_pkg::LOW_QUAD && a_mid8 <= low_end;
    // Base alignment is software's job; a misaligned base wraps oddly
    hit_mid = mid_written && shared_written && mem_cycle && !ctrl_block_hit_in
      && cyc_addr_in[19:13] >= mid_base && mid_off < mid_span;
    mid_idx = 2'(mid_off >> mid_shift);
    per_idx = cyc_addr_in[9:7];
    hit_per = periph_written && shared_written && !ctrl_block_hit_in
      && (periph_space_sel ? mem_cycle : io_cycle)
      && cyc_addr_in[19:10] == per_base && per_idx != csd_pkg::PERIPH_HOLE;
    // Wait policy of the select that won
    next_wait = 2'h0;
    next_rdis = 1'b0;
    if (hit_boot)
    begin
      next_wait = wait_field(boot_select_ctrl);
      next_rdis = boot_select_ctrl[csd_pkg::F_RDY_DIS];
    end
    else if (hit_low)
    begin
      next_wait = wait_field(low_select_ctrl);
      next_rdis = low_select_ctrl[csd_pkg::F_RDY_DIS];
    end
    else if (hit_mid)
    begin
      next_wait = wait_field(mid_select_ctrl);
      next_rdis = mid_select_ctrl[csd_pkg::F_RDY_DIS];
    end
    else if (hit_per && per_idx >= 3'h4)
    begin
      next_wait = wait_field(shared_select_ctrl);
      next_rdis = shared_select_ctrl[csd_pkg::F_RDY_DIS];
    end
    else if (hit_per)
    begin
      next_wait = wait_field(periph_select_ctrl);
      next_rdis = periph_select_ctrl[csd_pkg::F_RDY_DIS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Select outputs

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      boot_mem_select_n_out <= 1'b1;
      low_mem_select_n_out <= 1'b1;
      mid_mem_select_n_out <= 4'hf;
      periph_select_n_out <= 7'h7f;
    end
    else if (cyc_start_in)
    begin
      // Captured on the address edge itself
      boot_mem_select_n_out <= !hit_boot;
      low_mem_select_n_out <= !hit_low;
      mid_mem_select_n_out <= ~(4'(hit_mid) << mid_idx);
      periph_select_n_out <= ~(7'(hit_per) << per_idx);
    end
    else if (cyc_end_in)
    begin
      boot_mem_select_n_out <= 1'b1;
      low_mem_select_n_out <= 1'b1;
      mid_mem_select_n_out <= 4'hf;
      periph_select_n_out <= 7'h7f;
    end
  end

  csd_wait u_wait
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .load_in(cyc_start_in),
    .wait_count_in(next_wait),
    .ready_disable_in(next_rdis),
    .bus_ready_in(ready_sync2),
    .clear_in(cyc_end_in),
    .done_out(cycle_ready_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_halt_never_selects:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cyc_start_in && (cyc_status_in == csd_pkg::CSD_CYC_HALT
    || cyc_status_in == csd_pkg::CSD_CYC_INT_ACK) |=> &periph_select_n_out
    && &mid_mem_select_n_out && boot_mem_select_n_out && low_mem_select_n_out)
    else $error("select asserted on halt or acknowledge");

  a_ctrl_block_quiet:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cyc_start_in && ctrl_block_hit_in |=> boot_mem_select_n_out && &periph_select_n_out)
    else $error("select asserted on control block access");

  a_boot_top_hit:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cyc_start_in && mem_cycle && !ctrl_block_hit_in && cyc_addr_in[19:18] == csd_pkg::TOP_QUAD
    && cyc_addr_in[17:10] >= boot_select_ctrl[csd_pkg::F_A17_HI:csd_pkg::F_A17_LO]
    |=> !boot_mem_select_n_out)
    else $error("boot select missed");

  a_one_select_only:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $countones({~periph_select_n_out, ~mid_mem_select_n_out}) <= 1)
    else $error("two selects in one group");

  a_select_drops_end:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cyc_end_in && !cyc_start_in |=> boot_mem_select_n_out && low_mem_select_n_out
    && &mid_mem_select_n_out && &periph_select_n_out)
    else $error("select held past cycle end");

  a_low_needs_write:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !low_written |-> low_mem_select_n_out)
    else $error("low select before programming");

  a_periph_io_space:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cyc_start_in && !shared_select_ctrl[csd_pkg::F_SPACE] && mem_cycle |=> &periph_select_n_out)
    else $error("peripheral select on memory cycle in io mode");

  a_zero_wait_ready:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cyc_start_in && next_wait == 2'h0 && next_rdis ##1 !cyc_end_in [*2]
    |-> cycle_ready_out)
    else $error("zero wait cycle not ready in two clocks");

  a_ready_waits_pin:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cyc_start_in && !next_rdis ##1 (!ready_sync2 && !cyc_end_in) [*4]
    |=> !cycle_ready_out)
    else $error("ready given without bus ready");

endmodule : csd_decoder

// file: rtl/csd_wait_unused_guard.sv
`timescale 1ns/10ps

// file: bench/csd_biu_model.sv
`timescale 1ns/10ps
// Bus side: runs one cycle at a time and reports what the decoder showed
module csd_biu_model
(
  input wire logic clk_in,
  input wire logic [12:0] sel_n_in,
  input wire logic cycle_ready_in,
  output logic cyc_start_out,
  output logic cyc_end_out,
  output logic [19:0] cyc_addr_out,
  output logic [2:0] cyc_status_out,
  output logic ctrl_block_hit_out,
  output logic bus_ready_out
);
  initial
  begin
    cyc_start_out = 1'b0;
    cyc_end_out = 1'b0;
    cyc_addr_out = 20'h0_0000;
    cyc_status_out = 3'h7;
    ctrl_block_hit_out = 1'b0;
    bus_ready_out = 1'b0;
  end

  // Slow devices hold the ready pin low for rdy cycles; waits = cycles to ready
  task automatic bus_cycle(input logic [19:0] a, input logic [2:0] st, input logic h,
    input int rdy, output logic [12:0] sel, output logic [12:0] sel_end, output int waits);
    int n;
    @(negedge clk_in);
    cyc_start_out = 1'b1;
    cyc_addr_out = a;
    cyc_status_out = st;
    ctrl_block_hit_out = h;
    @(negedge clk_in);
    cyc_start_out = 1'b0;
    // Address is only valid with start, so show garbage afterwards
    cyc_addr_out = ~a;
    ctrl_block_hit_out = ~h;
    sel = sel_n_in;
    waits = 40;
    for (n = 1; n < 40; n++)
    begin
      if (n >= rdy)
        bus_ready_out = 1'b1;
      if (cycle_ready_in === 1'b1)
      begin
        waits = n;
        break;
      end
      @(negedge clk_in);
    end
    cyc_end_out = 1'b1;
    @(negedge clk_in);
    cyc_end_out = 1'b0;
    bus_ready_out = 1'b0;
    sel_end = sel_n_in;
  endtask : bus_cycle
endmodule : csd_biu_model

// file: bench/csd_decoder_tb_top.sv
`timescale 1ns/10ps
module csd_decoder_tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] cfg_data = 16'h0000;
  // Strobes: 4 boot, 3 low, 2 mid, 1 shared, 0 periph
  logic [4:0] wr = 5'h00;
  logic cyc_start, cyc_end, hit, bus_ready, cycle_ready;
  logic [19:0] addr;
  logic [2:0] status;
  wire logic [12:0] sel_n;
  int errors = 0;
  int tests_run = 0;

  always #2 clk_in = ~clk_in;

  csd_decoder csd_decoder_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .cyc_start_in(cyc_start),
    .cyc_end_in(cyc_end), .cyc_addr_in(addr), .cyc_status_in(status),
    .ctrl_block_hit_in(hit), .bus_ready_in(bus_ready), .cfg_data_in(cfg_data),
    .boot_select_ctrl_wr_in(wr[4]), .low_select_ctrl_wr_in(wr[3]),
    .mid_select_ctrl_wr_in(wr[2]), .shared_select_ctrl_wr_in(wr[1]),
    .periph_select_ctrl_wr_in(wr[0]), .boot_mem_select_n_out(sel_n[12]),
    .low_mem_select_n_out(sel_n[11]), .mid_mem_select_n_out(sel_n[10:7]),
    .periph_select_n_out(sel_n[6:0]), .cycle_ready_out(cycle_ready));

  csd_biu_model csd_biu_model_i (.clk_in(clk_in), .sel_n_in(sel_n),
    .cycle_ready_in(cycle_ready), .cyc_start_out(cyc_start), .cyc_end_out(cyc_end),
    .cyc_addr_out(addr), .cyc_status_out(status), .ctrl_block_hit_out(hit),
    .bus_ready_out(bus_ready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic ok(input logic c, input string what);
    tests_run++;
    if (c !== 1'b1)
    begin
      errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : ok

  task automatic cfg_write(input int which, input logic [15:0] data);
    @(negedge clk_in);
    cfg_data = data;
    wr[which] = 1'b1;
    @(negedge clk_in);
    wr = 5'h00;
  endtask : cfg_write

  // Every select must be released once the cycle ends
  task automatic probe(input logic [19:0] a, input logic [2:0] st, input logic h, input int rdy,
    input logic [12:0] exp, output int waits);
    logic [12:0] sel, sel_end;
    csd_biu_model_i.bus_cycle(a, st, h, rdy, sel, sel_end, waits);
    ok(sel === exp, "wrong select pattern");
    ok(sel_end === 13'h1fff, "select held after cycle end");
  endtask : probe

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    int w;
    ok(sel_n === 13'h1fff, "select active after reset");
    probe(20'hf_fff0, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 12, 13'h0fff, w);
    ok(w > 12, "boot cycle ended before ready");
    probe(20'h0_0010, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 1, 13'h1fff, w);
    probe(20'h2_0000, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 1, 13'h1fff, w);
    probe(20'h0_4000, csd_pkg::CSD_CYC_IO_READ, 1'b0, 1, 13'h1fff, w);
    $display("t_reset finished");
  endtask : t_reset

  task automatic t_types;
    int w;
    logic [12:0] exp;
    for (int s = 0; s < 7; s++)
    begin
      exp = (s >= 4) ? 13'h0fff : 13'h1fff;
      probe(20'hf_ff00, 3'(s), 1'b0, 1, exp, w);
    end
    probe(20'hf_ff00, csd_pkg::CSD_CYC_MEM_READ, 1'b1, 1, 13'h1fff, w);
    probe(20'hf_fbff, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 1, 13'h1fff, w);
    $display("t_types finished");
  endtask : t_types

  task automatic t_low;
    int w0, w3, w;
    cfg_write(3, 16'h01c4);
    probe(20'h0_1fff, csd_pkg::CSD_CYC_MEM_WRITE, 1'b0, 30, 13'h17ff, w0);
    ok(w0 < 30, "ready awaited though disabled");
    probe(20'h0_2000, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 1, 13'h1fff, w);
    probe(20'h4_0000, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 1, 13'h1fff, w);
    probe(20'h0_1000, csd_pkg::CSD_CYC_IO_READ, 1'b0, 1, 13'h1fff, w);
    cfg_write(3, 16'h01c7);
    probe(20'h0_0000, csd_pkg::CSD_CYC_FETCH, 1'b0, 30, 13'h17ff, w3);
    ok(w3 - w0 == 3, "wait state count");
    $display("t_low finished");
  endtask : t_low

  task automatic t_mid;
    int w;
    logic [12:0] exp;
    cfg_write(2, 16'h2004);
    probe(20'h2_0000, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 1, 13'h1fff, w);
    cfg_write(1, 16'h0100);
    for (int k = 0; k < 5; k++)
    begin
      exp = (k < 4) ? ~(13'h0080 << k) : 13'h1fff;
      probe(20'h2_0000 + 20'(k * 2048), csd_pkg::CSD_CYC_MEM_READ, 1'b0, 1, exp, w);
    end
    probe(20'h2_0000, csd_pkg::CSD_CYC_IO_READ, 1'b0, 1, 13'h1fff, w);
    $display("t_mid finished");
  endtask : t_mid

  task automatic t_periph;
    int w, w0, w4;
    logic [12:0] exp;
    cfg_write(0, 16'h0404);
    for (int k = 0; k < 8; k++)
    begin
      exp = (k < 7) ? ~(13'h0001 << k) : 13'h1fff;
      probe(20'h0_4000 + 20'(k * 128), csd_pkg::CSD_CYC_IO_WRITE, 1'b0, 1, exp, w);
    end
    probe(20'h0_4000, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 1, 13'h1fff, w);
    cfg_write(1, 16'h0144);
    probe(20'h0_4000, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 1, 13'h1ffe, w0);
    probe(20'h0_4000, csd_pkg::CSD_CYC_IO_READ, 1'b0, 1, 13'h1fff, w);
    // Upper slices take their wait policy from the shared word, lower ones from their own
    cfg_write(1, 16'h0146);
    cfg_write(0, 16'h0400);
    probe(20'h0_4200, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 30, 13'h1fef, w4);
    ok(w4 - w0 == 2, "shared wait count not applied");
    probe(20'h0_4000, csd_pkg::CSD_CYC_MEM_READ, 1'b0, 8, 13'h1ffe, w);
    ok(w > 8, "ready pin ignored though required");
    $display("t_periph finished");
  endtask : t_periph

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_types();
    t_low();
    t_mid();
    t_periph();
    test_done();
  end

  // About 40 cycles of 40 at most each, so 40 us is far beyond a healthy run
  initial
  begin
    #40000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule : csd_decoder_tb_top
